//--- src/hsr_pkg.sv
// Constants for the hot-swap status reporting block
// Contract
// - Summary word read at command 0x79, bit 11 set in reset as power ok output resets low.
// - Summary bit 15 is live: any output voltage flag set.
// - Summary bit 14 is live: any output current flag set.
// - Summary bit 13 is live: any input flag set.
// - Summary bit 12 is live: any manufacturer flag set.
// - Summary bit 11 reads power bad, inverse of power ok output.
// - Summary low byte equals the single status byte at that moment.
// - Reserved bits read zero, summary 10:8 and output bytes 4:0.
// - Output voltage byte at 0x7A, reset zero, only with sense pin.
// - Output voltage bit 6 latches on output overvoltage.
// - Output voltage bit 5 latches on output undervoltage.
// - Output current byte at 0x7B, reset zero.
// - Output current bit 7 latches on timed-out overcurrent with gate off.
// - Output current bit 5 latches when current exceeds warning limit.
// - Input byte at 0x7C, reset zero, bits 3:0 read zero.
// - Input bit 7 latches on overvoltage comparator pin.
// - Input bit 6 latches on input overvoltage warning.
// - Input bit 5 latches on input undervoltage warning.
// - Input bit 4 latches on undervoltage comparator pin.
// - Status byte bit 6 is live while gate drive is disabled.
// - Overcurrent warning compares 12-bit threshold with measured current.
package hsr_pkg;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_AGGREGATE_STATUS_16 = 8'h79;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FLAGS = 8'h7A;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_FLAGS = 8'h7B;
  localparam logic [7:0] CMD_INPUT_SUPPLY_FLAGS = 8'h7C;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int ADC_WIDTH = 12;
  // Summary word bits
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_MFR = 12;
  localparam int SW_POWER_BAD = 11;
  // Status byte bits
  localparam int SB_GATE_OFF = 6;
  localparam int SB_OC_FAULT = 4;
  localparam int SB_UV_FAULT = 3;
  localparam int SB_CML = 1;
  localparam int SB_OTHER = 0;
  // Output voltage byte bits
  localparam int VO_OV_WARN = 6;
  localparam int VO_UV_WARN = 5;
  // Output current byte bits
  localparam int IO_OC_FAULT = 7;
  localparam int IO_OC_WARN = 5;
  // Input byte bits
  localparam int IN_OV_FAULT = 7;
  localparam int IN_OV_WARN = 6;
  localparam int IN_UV_WARN = 5;
  localparam int IN_UV_FAULT = 4;
  typedef enum logic [1:0] {
    HSR_LINK_IDLE,
    HSR_LINK_WAIT,
    HSR_LINK_DONE
  } hsr_link_state_type;
endpackage

//--- src/hsr_status_regs.sv
// Status reporting registers with a link-clock command port
`timescale 1ns/1ps
`default_nettype none
module hsr_status_regs #(
  parameter bit HAS_VOUT_SENSE = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic output_feedback_pin,
  input wire logic ov_comparator_pin,
  input wire logic uv_comparator_pin,
  input wire logic gate_drive_disabled,
  input wire logic oc_timer_expired,
  input wire logic vout_ov_warn_event,
  input wire logic vout_uv_warn_event,
  input wire logic vin_ov_warn_event,
  input wire logic vin_uv_warn_event,
  input wire logic [hsr_pkg::ADC_WIDTH-1:0] current_sample,
  input wire logic current_sample_valid,
  input wire logic [hsr_pkg::ADC_WIDTH-1:0] overcurrent_warning_threshold,
  input wire logic mfr_flags_active,
  output logic power_ok_output,
  input wire logic link_clk,
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  output logic cmd_busy,
  output logic [15:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_error
);
  // Pin synchronisers
  logic fb_meta;
  logic fb_sync;
  logic ov_meta;
  logic ov_sync;
  logic uv_meta;
  logic uv_sync;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fb_meta <= 1'b0;
      fb_sync <= 1'b0;
      ov_meta <= 1'b0;
      ov_sync <= 1'b0;
      uv_meta <= 1'b0;
      uv_sync <= 1'b0;
    end else begin
      fb_meta <= output_feedback_pin;
      fb_sync <= fb_meta;
      ov_meta <= ov_comparator_pin;
      ov_sync <= ov_meta;
      uv_meta <= uv_comparator_pin;
      uv_sync <= uv_meta;
    end
  end

  // Power good output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_ok_output <= 1'b0;
    end else begin
      power_ok_output <= fb_sync;
    end
  end

  // Command request crossing into the core domain
  logic req_tgl;
  logic [7:0] req_code;
  logic req_meta;
  logic req_sync;
  logic req_seen;
  logic req_take;
  logic ack_tgl;
  logic [15:0] ack_data;
  logic ack_err;
  logic clear_req;
  logic cml_event;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      req_meta <= req_tgl;
      req_sync <= req_meta;
      req_seen <= req_sync;
    end
  end
  assign req_take = req_sync ^ req_seen;

  // Latched flags
  logic [7:0] vout_flags;
  logic [7:0] iout_flags;
  logic [7:0] input_flags;
  logic oc_fault_event;
  logic oc_warn_event;
  logic cml_flag;
  assign oc_fault_event = oc_timer_expired & gate_drive_disabled;
  assign oc_warn_event = current_sample_valid &
      (current_sample > overcurrent_warning_threshold);
  assign clear_req = req_take & (req_code == hsr_pkg::CMD_CLEAR_FAULTS);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vout_flags <= hsr_pkg::RESET_BYTE;
    end else begin
      if (clear_req) begin
        vout_flags <= hsr_pkg::RESET_BYTE;
      end
      if (HAS_VOUT_SENSE && vout_ov_warn_event) begin
        vout_flags[hsr_pkg::VO_OV_WARN] <= 1'b1;
      end
      if (HAS_VOUT_SENSE && vout_uv_warn_event) begin
        vout_flags[hsr_pkg::VO_UV_WARN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      iout_flags <= hsr_pkg::RESET_BYTE;
    end else begin
      if (clear_req) begin
        iout_flags <= hsr_pkg::RESET_BYTE;
      end
      if (oc_fault_event) begin
        iout_flags[hsr_pkg::IO_OC_FAULT] <= 1'b1;
      end
      if (oc_warn_event) begin
        iout_flags[hsr_pkg::IO_OC_WARN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input_flags <= hsr_pkg::RESET_BYTE;
    end else begin
      if (clear_req) begin
        input_flags <= hsr_pkg::RESET_BYTE;
      end
      if (ov_sync) begin
        input_flags[hsr_pkg::IN_OV_FAULT] <= 1'b1;
      end
      if (vin_ov_warn_event) begin
        input_flags[hsr_pkg::IN_OV_WARN] <= 1'b1;
      end
      if (vin_uv_warn_event) begin
        input_flags[hsr_pkg::IN_UV_WARN] <= 1'b1;
      end
      if (uv_sync) begin
        input_flags[hsr_pkg::IN_UV_FAULT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cml_flag <= 1'b0;
    end else if (cml_event) begin
      cml_flag <= 1'b1;
    end else if (clear_req) begin
      cml_flag <= 1'b0;
    end
  end

  // Status views
  logic [7:0] status_byte;
  logic [15:0] summary_word;
  always_comb begin
    status_byte = hsr_pkg::RESET_BYTE;
    status_byte[hsr_pkg::SB_GATE_OFF] = gate_drive_disabled;
    status_byte[hsr_pkg::SB_OC_FAULT] = iout_flags[hsr_pkg::IO_OC_FAULT];
    status_byte[hsr_pkg::SB_UV_FAULT] = input_flags[hsr_pkg::IN_UV_FAULT];
    status_byte[hsr_pkg::SB_CML] = cml_flag;
    status_byte[hsr_pkg::SB_OTHER] = (|vout_flags) | (|iout_flags) |
        (|input_flags) | mfr_flags_active;
  end
  always_comb begin
    summary_word = hsr_pkg::RESET_WORD;
    summary_word[hsr_pkg::SW_VOUT] = |vout_flags;
    summary_word[hsr_pkg::SW_IOUT] = |iout_flags;
    summary_word[hsr_pkg::SW_INPUT] = |input_flags;
    summary_word[hsr_pkg::SW_MFR] = mfr_flags_active;
    summary_word[hsr_pkg::SW_POWER_BAD] = ~power_ok_output;
    summary_word[7:0] = status_byte;
  end

  // Command decode and answer capture
  logic [15:0] next_ack_data;
  logic next_ack_err;
  always_comb begin
    next_ack_data = hsr_pkg::RESET_WORD;
    next_ack_err = 1'b0;
    case (req_code)
      hsr_pkg::CMD_CLEAR_FAULTS: next_ack_data = hsr_pkg::RESET_WORD;
      hsr_pkg::CMD_STATUS_BYTE: next_ack_data = {8'h00, status_byte};
      hsr_pkg::CMD_AGGREGATE_STATUS_16: next_ack_data = summary_word;
      hsr_pkg::CMD_OUTPUT_VOLTAGE_FLAGS: begin
        if (HAS_VOUT_SENSE) begin
          next_ack_data = {8'h00, vout_flags};
        end else begin
          next_ack_err = 1'b1;
        end
      end
      hsr_pkg::CMD_OUTPUT_CURRENT_FLAGS: next_ack_data = {8'h00, iout_flags};
      hsr_pkg::CMD_INPUT_SUPPLY_FLAGS: next_ack_data = {8'h00, input_flags};
      default: next_ack_err = 1'b1;
    endcase
  end
  assign cml_event = req_take & next_ack_err;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_data <= hsr_pkg::RESET_WORD;
      ack_err <= 1'b0;
      ack_tgl <= 1'b0;
    end else if (req_take) begin
      ack_data <= next_ack_data;
      ack_err <= next_ack_err;
      ack_tgl <= ~ack_tgl;
    end
  end

  // Link domain reset
  logic lrst_meta;
  logic link_rst;
  always_ff @(posedge link_clk) begin
    lrst_meta <= sys_rst;
    link_rst <= lrst_meta;
  end

  // Answer crossing into the link domain
  logic ack_meta;
  logic ack_sync;
  logic ack_seen;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      ack_meta <= ack_tgl;
      ack_sync <= ack_meta;
      ack_seen <= ack_sync;
    end
  end

  // Link-side command sequencer
  hsr_pkg::hsr_link_state_type link_state;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_state <= hsr_pkg::HSR_LINK_IDLE;
      req_tgl <= 1'b0;
      req_code <= 8'h00;
      cmd_busy <= 1'b0;
      rsp_data <= hsr_pkg::RESET_WORD;
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (link_state)
        hsr_pkg::HSR_LINK_IDLE: begin
          if (cmd_strobe) begin
            req_code <= cmd_code;
            req_tgl <= ~req_tgl;
            cmd_busy <= 1'b1;
            link_state <= hsr_pkg::HSR_LINK_WAIT;
          end
        end
        hsr_pkg::HSR_LINK_WAIT: begin
          if (ack_sync ^ ack_seen) begin
            rsp_data <= ack_data;
            rsp_error <= ack_err;
            rsp_valid <= 1'b1;
            link_state <= hsr_pkg::HSR_LINK_DONE;
          end
        end
        hsr_pkg::HSR_LINK_DONE: begin
          cmd_busy <= 1'b0;
          link_state <= hsr_pkg::HSR_LINK_IDLE;
        end
        default: link_state <= hsr_pkg::HSR_LINK_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verification/hsr_status_monitor.sv
// Checker for the status block ports
`timescale 1ns/1ps
`default_nettype none
module hsr_status_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic output_feedback_pin,
  input wire logic power_ok_output,
  input wire logic link_clk,
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_busy,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_error
);
  logic [7:0] lc;
  logic [2:0] up_cnt;
  logic ok;
  always_ff @(posedge link_clk) begin
    if (sys_rst) lc <= 8'h00;
    else if (cmd_strobe && !cmd_busy) lc <= cmd_code;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  assign ok = rsp_valid && !rsp_error;
  power_follow_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    up_cnt > 3'h4 |-> power_ok_output == $past(output_feedback_pin, 3))
    else $error("power ok lag wrong");
  answer_time_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    cmd_strobe && !cmd_busy |=> cmd_busy ##[3:10] rsp_valid)
    else $error("answer late");
  answer_pulse_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    rsp_valid |=> !rsp_valid && !cmd_busy)
    else $error("answer not a pulse");
  refused_zero_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    rsp_valid && rsp_error |-> rsp_data == 16'h0000)
    else $error("refused data");
  word_reserved_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    ok && lc == 8'h79 |-> rsp_data[10:8] == 3'h0)
    else $error("word reserved");
  word_points_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    ok && lc == 8'h79 && rsp_data[15:12] != 4'h0 |-> rsp_data[0])
    else $error("word low byte");
  vout_bits_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    ok && lc == 8'h7A |-> rsp_data[15:7] == 9'h0 && rsp_data[4:0] == 5'h0)
    else $error("vout reserved");
  iout_bits_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    ok && lc == 8'h7B |-> rsp_data[15:8] == 8'h0 && rsp_data[6] == 1'b0
    && rsp_data[4:0] == 5'h0)
    else $error("iout reserved");
  input_bits_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    ok && lc == 8'h7C |-> rsp_data[15:8] == 8'h0 && rsp_data[3:0] == 4'h0)
    else $error("input reserved");
  cover property (@(posedge link_clk) rsp_valid && rsp_error);
  cover property (@(posedge link_clk) ok && lc == 8'h79 && rsp_data[15]);
  cover property (@(posedge clk) $fell(power_ok_output));
endmodule
`default_nettype wire

//--- verification/hsr_host_model.sv
// Host model issuing status commands on the link port
`timescale 1ns/1ps
`default_nettype none
module hsr_host_model (
  input wire logic link_clk,
  output logic cmd_strobe,
  output logic [7:0] cmd_code,
  input wire logic cmd_busy,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_error
);
  initial begin
    cmd_strobe = 1'b0;
    cmd_code = 8'h00;
  end
  // One command at a time, answer taken at its edge
  task automatic read(input logic [7:0] c, output logic [15:0] d,
    output logic e, output logic to);
    to = 1'b1;
    d = 16'h0000;
    e = 1'b0;
    @(posedge link_clk);
    for (int n = 0; cmd_busy !== 1'b0 && n < 20; n++) @(posedge link_clk);
    #1 cmd_strobe = 1'b1;
    cmd_code = c;
    @(posedge link_clk);
    #1 cmd_strobe = 1'b0;
    cmd_code = ~c;
    for (int n = 0; n < 20 && to; n++) begin
      @(posedge link_clk);
      if (rsp_valid === 1'b1) begin
        d = rsp_data;
        e = rsp_error;
        to = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- verification/hsr_status_regs_tb.sv
// Testbench for the status reporting block
`timescale 1ns/1ps
`default_nettype none
module hsr_status_regs_tb;
  logic clk, sys_rst, link_clk, fb, gate, mfr, pok, stb, busy, rv, re;
  logic [7:0] ev, code;
  logic [11:0] cs, th;
  logic [15:0] rdat;
  int n_mismatch, n_compared;
  hsr_status_regs dut_u (.clk(clk), .sys_rst(sys_rst),
    .output_feedback_pin(fb), .ov_comparator_pin(ev[3]),
    .uv_comparator_pin(ev[2]), .gate_drive_disabled(gate),
    .oc_timer_expired(ev[1]), .vout_ov_warn_event(ev[7]),
    .vout_uv_warn_event(ev[6]), .vin_ov_warn_event(ev[5]),
    .vin_uv_warn_event(ev[4]), .current_sample(cs),
    .current_sample_valid(ev[0]), .overcurrent_warning_threshold(th),
    .mfr_flags_active(mfr), .power_ok_output(pok), .link_clk(link_clk),
    .cmd_strobe(stb), .cmd_code(code), .cmd_busy(busy), .rsp_data(rdat),
    .rsp_valid(rv), .rsp_error(re));
  hsr_host_model host_u (.link_clk(link_clk), .cmd_strobe(stb),
    .cmd_code(code), .cmd_busy(busy), .rsp_data(rdat), .rsp_valid(rv),
    .rsp_error(re));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] s,
    input logic [15:0] x);
    n_compared++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] x, input logic xe);
    logic [15:0] d;
    logic e, to;
    host_u.read(c, d, e, to);
    if (to) begin
      n_mismatch++;
      $display("mismatch answer to %h expected reply seen none", c);
      end_of_test();
    end
    check($sformatf("data of %h", c), d, x);
    check($sformatf("error of %h", c), {15'h0, e}, {15'h0, xe});
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk) #1 ev = m;
    repeat (3) @(posedge clk);
    #1 ev = 8'h00;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  initial begin
    {sys_rst, fb, gate, mfr, ev, cs, th} = {4'hC, 8'h00, 12'h000, 12'h800};
    n_mismatch = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    repeat (4) @(posedge link_clk);
    @(posedge clk) #1 sys_rst = 1'b0;
    repeat (4) @(posedge link_clk);
    check("power ok", {15'h0, pok}, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      rd(8'h78 + 8'(i), 16'h0000, 1'b0);
    end
    $display("test reset values done");
    pulse(8'h80);
    rd(8'h7A, 16'h0040, 1'b0);
    pulse(8'h40);
    rd(8'h7A, 16'h0060, 1'b0);
    rd(8'h79, 16'h8001, 1'b0);
    $display("test output voltage done");
    pulse(8'h01);
    rd(8'h7B, 16'h0000, 1'b0);
    @(posedge clk) #1 cs = 12'h801;
    pulse(8'h01);
    rd(8'h7B, 16'h0020, 1'b0);
    @(posedge clk) #1 gate = 1'b1;
    pulse(8'h02);
    rd(8'h7B, 16'h00A0, 1'b0);
    rd(8'h78, 16'h0051, 1'b0);
    $display("test output current done");
    pulse(8'h3C);
    rd(8'h7C, 16'h00F0, 1'b0);
    @(posedge clk) #1 fb = 1'b0;
    mfr = 1'b1;
    repeat (4) @(posedge clk);
    check("power ok", {15'h0, pok}, 16'h0000);
    rd(8'h79, 16'hF859, 1'b0);
    @(posedge clk) #1 gate = 1'b0;
    rd(8'h78, 16'h0019, 1'b0);
    $display("test summary word done");
    rd(8'h03, 16'h0000, 1'b0);
    rd(8'h79, 16'h1801, 1'b0);
    rd(8'h55, 16'h0000, 1'b1);
    rd(8'h78, 16'h0003, 1'b0);
    @(posedge clk) #1 fb = 1'b1;
    mfr = 1'b0;
    rd(8'h03, 16'h0000, 1'b0);
    rd(8'h79, 16'h0000, 1'b0);
    $display("test clear faults done");
    end_of_test();
  end
endmodule
bind hsr_status_regs hsr_status_monitor mon_u (.clk(clk), .sys_rst(sys_rst),
  .output_feedback_pin(output_feedback_pin),
  .power_ok_output(power_ok_output), .link_clk(link_clk),
  .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .cmd_busy(cmd_busy),
  .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_error(rsp_error));
`default_nettype wire
